// *** rtl/pcr_phy_control_regs.sv ***
// Purpose: PHY control registers one and two and the logic they steer.
// Assumes: Inputs are synchronous to clk; ce marks each nibble and symbol slot.
// Notes: Management port carries already-decoded serial management accesses.
`timescale 1ns/1ps
module pcr_phy_control_regs #(
	parameter int SLOT_CYC = pcr_pkg::XOVER_SLOT_CYC
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Management access
	input wire pcr_pkg::pcr_mgmt_req_t mgmtReq,
	output logic [15:0] mgmtRdData,
	output logic mgmtRdValid,
	// Link and diagnostics
	input wire logic linkUp,
	input wire logic energyDet,
	output logic diagStart,
	// Crossover
	output logic autoMdixOn,
	output logic mdixSwap,
	// Duplex resolution
	input wire logic anEnable,
	input wire logic forced100,
	input wire logic partnerForced100,
	input wire logic ieeeFullDuplex,
	output logic fullDuplex,
	// Receive toward MAC
	input wire pcr_pkg::pcr_sym_t rxSym,
	output logic rxDv,
	output logic rxEr,
	// Transmit from MAC
	input wire logic txEnIn,
	input wire logic txErIn,
	output logic txEnOut,
	output logic txErOut
);
	import pcr_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	logic [15:0] ctrlOne_q, ctrlTwo_q;
	logic [15:0] rdData_q;
	logic rdValid_q;

	wire hitOne = (mgmtReq.addr == CTRL_ONE_ADDR);
	wire hitTwo = (mgmtReq.addr == CTRL_TWO_ADDR);
	wire wrOne = mgmtReq.wr && hitOne;
	wire wrTwo = mgmtReq.wr && hitTwo;
	// Unmapped addresses answer zero so the serial side always has a value to shift.
	wire [15:0] rdMux = hitOne ? ctrlOne_q : (hitTwo ? ctrlTwo_q : CTRL_RESET);

	wire diagEn = ctrlOne_q[DIAG_BIT];
	wire robustEn = ctrlOne_q[XOVER_BIT];
	wire earlyEn = ctrlOne_q[EARLY_RXDV_BIT];
	wire extFdxEn = ctrlTwo_q[EXT_FDX_BIT];
	wire idleErrEn = ctrlTwo_q[IDLE_ERR_BIT];
	wire oddNibDis = ctrlTwo_q[ODD_NIB_DIS_BIT];

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrlOne_q <= CTRL_RESET;
			ctrlTwo_q <= CTRL_RESET;
		end else if (ce) begin
			if (wrOne) begin
				ctrlOne_q <= mgmtReq.data & CTRL_ONE_WR_MASK;
			end
			if (wrTwo) begin
				ctrlTwo_q <= mgmtReq.data & CTRL_TWO_WR_MASK;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdData_q <= CTRL_RESET;
			rdValid_q <= 1'b0;
		end else if (ce) begin
			rdValid_q <= mgmtReq.rd;
			if (mgmtReq.rd) begin
				rdData_q <= rdMux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	logic linkPrev_q, diag_q;
	wire linkDrop = linkPrev_q && !linkUp;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			linkPrev_q <= 1'b0;
			diag_q <= 1'b0;
		end else if (ce) begin
			linkPrev_q <= linkUp;
			diag_q <= diagEn && linkDrop;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// A pseudo-random slot extension keeps two identical ends from hopping in lockstep.
	logic [11:0] slotCnt_q;
	logic [3:0] lfsr_q;
	logic swap_q, autoOn_q;
	wire hunting = robustEn && !linkUp && !energyDet;
	wire slotDone = (slotCnt_q == 12'h000);
	wire [11:0] slotLoad = 12'(SLOT_CYC - 1) + {8'h00, lfsr_q};

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			slotCnt_q <= 12'h000;
			lfsr_q <= 4'h1;
			swap_q <= 1'b0;
			autoOn_q <= 1'b0;
		end else if (ce) begin
			autoOn_q <= robustEn;
			lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
			if (!robustEn) begin
				swap_q <= 1'b0;
				slotCnt_q <= 12'h000;
			end else if (hunting) begin
				if (slotDone) begin
					swap_q <= !swap_q;
					slotCnt_q <= slotLoad;
				end else begin
					slotCnt_q <= slotCnt_q - 12'h001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	logic fdx_q;
	wire extFdxHit = extFdxEn && (anEnable || forced100) && partnerForced100;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fdx_q <= 1'b0;
		end else if (ce) begin
			fdx_q <= extFdxHit ? 1'b1 : ieeeFullDuplex;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Parity counts nibbles taken while the MAC enable is high.
	logic txPrev_q, nibOdd_q, txEn_q, txEr_q;
	wire oddEnd = txPrev_q && !txEnIn && nibOdd_q && !oddNibDis;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			txPrev_q <= 1'b0;
			nibOdd_q <= 1'b0;
			txEn_q <= 1'b0;
			txEr_q <= 1'b0;
		end else if (ce) begin
			txPrev_q <= txEnIn;
			nibOdd_q <= txEnIn ? !nibOdd_q : 1'b0;
			txEn_q <= txEnIn || oddEnd;
			txEr_q <= (txEnIn && txErIn) || oddEnd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	pcr_rx_sos u_rx (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.sym(rxSym),
		.earlyEn(earlyEn),
		.idleErrEn(idleErrEn),
		.rxDv(rxDv),
		.rxEr(rxEr)
	);

	assign mgmtRdData = rdData_q;
	assign mgmtRdValid = rdValid_q;
	assign diagStart = diag_q;
	assign autoMdixOn = autoOn_q;
	assign mdixSwap = swap_q;
	assign fullDuplex = fdx_q;
	assign txEnOut = txEn_q;
	assign txErOut = txEr_q;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	reserved_zero_a: assert property (
		(ctrlOne_q & ~CTRL_ONE_WR_MASK) == CTRL_RESET
		&& (ctrlTwo_q & ~CTRL_TWO_WR_MASK) == CTRL_RESET)
		else $error("Reserved control bits became nonzero.");
	write_read_a: assert property (
		ce && wrOne ##1 ce && mgmtReq.rd && hitOne && !mgmtReq.wr
		|=> mgmtRdValid && mgmtRdData == ($past(mgmtReq.data, 2) & CTRL_ONE_WR_MASK))
		else $error("Register one readback differs from write.");
	two_addr_a: assert property (
		ce && mgmtReq.rd && hitTwo |=> mgmtRdData == $past(ctrlTwo_q))
		else $error("Register two readback wrong.");
	diag_start_a: assert property (
		ce && linkDrop |=> diagStart == $past(diagEn))
		else $error("Diagnostics start does not follow link loss.");
	mdix_off_a: assert property (
		ce && !robustEn |=> !mdixSwap && !autoMdixOn)
		else $error("Crossover active while disabled.");
	mdix_hop_a: assert property (
		ce && hunting && slotDone |=> mdixSwap != $past(mdixSwap))
		else $error("Crossover did not hop at slot end.");
	ext_fdx_a: assert property (
		ce && extFdxHit |=> fullDuplex)
		else $error("Extended full duplex not applied.");
	ieee_fdx_a: assert property (
		ce && !extFdxEn |=> fullDuplex == $past(ieeeFullDuplex))
		else $error("Duplex does not follow standard resolution.");
	odd_extend_a: assert property (
		ce && oddEnd |=> txEnOut && txErOut)
		else $error("Odd-nibble end not extended with error.");
	odd_off_a: assert property (
		ce && oddNibDis && !txEnIn |=> !txEnOut)
		else $error("Transmit extended while detection disabled.");

	odd_end_c: cover property (ce && oddEnd);
	diag_c: cover property (diagStart);
	hop_c: cover property (ce && hunting && slotDone);
endmodule

// *** common/pcr_pkg.sv ***
// Purpose: Shared constants and carriers for the PHY control register pair.
// Assumes: Management accesses arrive already decoded from the serial frame.
// Notes: Only writable fields are stored; everything else reads as zero.
package pcr_pkg;

	localparam logic [4:0] CTRL_ONE_ADDR = 5'h09;
	localparam logic [4:0] CTRL_TWO_ADDR = 5'h0A;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CTRL_ONE_WR_MASK = 16'h0122;
	localparam logic [15:0] CTRL_TWO_WR_MASK = 16'h0026;

	localparam int DIAG_BIT = 8;
	localparam int XOVER_BIT = 5;
	localparam int EARLY_RXDV_BIT = 1;
	localparam int EXT_FDX_BIT = 5;
	localparam int IDLE_ERR_BIT = 2;
	localparam int ODD_NIB_DIS_BIT = 1;

	localparam int CLK_PERIOD_NS = 25;
	localparam int XOVER_SLOT_NS = 80000;
	localparam int XOVER_SLOT_CYC = (XOVER_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [15:0] data;
	} pcr_mgmt_req_t;

	typedef struct packed {
		logic valid;
		logic isJ;
		logic isK;
		logic isIdle;
		logic isErr;
	} pcr_sym_t;

endpackage

// *** rtl/pcr_rx_sos.sv ***
// Purpose: Start-of-stream detection driving the receive valid and error strobes.
// Assumes: One decoded symbol per clock enable, flagged by valid.
// Notes: Frame ends on the first idle symbol after the start delimiter.
`timescale 1ns/1ps
module pcr_rx_sos (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Symbol stream and modes
	input wire pcr_pkg::pcr_sym_t sym,
	input wire logic earlyEn,
	input wire logic idleErrEn,
	// Toward the MAC
	output logic rxDv,
	output logic rxEr
);
	import pcr_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_GOT_J, ST_FRAME} pcr_rx_state_t;
	pcr_rx_state_t state_q, state_d;
	logic rxDv_q, rxDv_d, rxEr_q, rxEr_d;

	always_comb begin
		state_d = state_q;
		rxDv_d = rxDv_q;
		rxEr_d = 1'b0;
		if (sym.valid) begin
			unique case (state_q)
				ST_IDLE: begin
					if (sym.isJ) begin
						state_d = ST_GOT_J;
						rxDv_d = earlyEn;
					end else if (sym.isErr && idleErrEn) begin
						rxEr_d = 1'b1;
					end
				end
				ST_GOT_J: begin
					if (sym.isK) begin
						state_d = ST_FRAME;
						rxDv_d = 1'b1;
					end else begin
						state_d = ST_IDLE;
						rxDv_d = 1'b0;
						rxEr_d = earlyEn;
					end
				end
				ST_FRAME: begin
					if (sym.isIdle) begin
						state_d = ST_IDLE;
						rxDv_d = 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			rxDv_q <= 1'b0;
			rxEr_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			rxDv_q <= rxDv_d;
			rxEr_q <= rxEr_d;
		end
	end

	assign rxDv = rxDv_q;
	assign rxEr = rxEr_q;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	early_dv_on_a: assert property (
		ce && earlyEn && sym.valid && sym.isJ && state_q == ST_IDLE |=> rxDv)
		else $error("Receive valid not raised on J in early mode.");
	normal_dv_wait_a: assert property (
		ce && !earlyEn && sym.valid && sym.isJ && state_q == ST_IDLE |=> !rxDv)
		else $error("Receive valid raised before K in normal mode.");
	bad_k_err_a: assert property (
		ce && earlyEn && sym.valid && !sym.isK && state_q == ST_GOT_J |=> rxEr && !rxDv)
		else $error("Missing receive error after J without K.");
	idle_err_off_a: assert property (
		ce && !idleErrEn && state_q == ST_IDLE |=> !rxEr)
		else $error("Idle symbol error reported while disabled.");

	early_frame_c: cover property (ce && earlyEn && state_q == ST_GOT_J && sym.valid && sym.isK);
	idle_err_c: cover property (ce && idleErrEn && rxEr);
endmodule

// *** tb/pcr_link_model.sv ***
// Purpose: MAC and line partner feeding symbols, nibbles and link state.
// Assumes: Every move is made on the falling edge of clk.
// Notes: A symbol slot that is not valid carries flipped flags as junk.
`timescale 1ns/1ps
module pcr_link_model (
	// Clock
	input wire logic clk,
	// Toward the block
	output pcr_pkg::pcr_sym_t rxSym,
	output logic linkUp,
	output logic energyDet,
	output logic txEnIn,
	output logic txErIn
);
	import pcr_pkg::*;
	initial begin
		rxSym = '0;
		linkUp = 1'h1;
		energyDet = 1'h0;
		txEnIn = 1'h0;
		txErIn = 1'h0;
	end
	task automatic sym(input logic [3:0] k);
		@(negedge clk);
		rxSym = {1'h1, k};
	endtask
	task automatic quiet;
		@(negedge clk);
		rxSym = {1'h0, ~rxSym[3:0]};
	endtask
	task automatic setLine(input logic l, input logic e);
		@(negedge clk);
		linkUp = l;
		energyDet = e;
	endtask
	task automatic tx(input int n, input logic e);
		repeat (n) begin
			@(negedge clk);
			txEnIn = 1'h1;
			txErIn = e;
		end
		@(negedge clk);
		txEnIn = 1'h0;
		txErIn = 1'h0;
	endtask
endmodule

// *** tb/pcr_phy_control_regs_bench.sv ***
// Purpose: Self-checking bench for the PHY control register pair.
// Assumes: ce held high except while ceTest writes, so every clock is one symbol slot.
// Notes: The hop slot is cut to 8 cycles to keep the run short.
`timescale 1ns/1ps
module pcr_phy_control_regs_bench;
	import pcr_pkg::*;
	logic clk, sysRst, ce, mgmtRdValid, linkUp, energyDet, diagStart;
	logic autoMdixOn, mdixSwap, anEnable, forced100, partnerForced100;
	logic ieeeFullDuplex, fullDuplex, rxDv, rxEr, txEnIn, txErIn, txEnOut, txErOut;
	logic [15:0] mgmtRdData;
	pcr_mgmt_req_t mgmtReq;
	pcr_sym_t rxSym;
	int nFail, checked;
	pcr_phy_control_regs #(.SLOT_CYC(8)) dut (.clk, .sys_rst(sysRst), .ce, .mgmtReq,
		.mgmtRdData, .mgmtRdValid, .linkUp, .energyDet, .diagStart, .autoMdixOn,
		.mdixSwap, .anEnable, .forced100, .partnerForced100, .ieeeFullDuplex,
		.fullDuplex, .rxSym, .rxDv, .rxEr, .txEnIn, .txErIn, .txEnOut, .txErOut);
	pcr_link_model mac (.clk, .rxSym, .linkUp, .energyDet, .txEnIn, .txErIn);
	////////////////////////////////////////////////////////////////////////
	task automatic results;
		if (nFail == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			nFail++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk);
		mgmtReq = {1'h1, 1'h0, a, d};
		@(negedge clk);
		mgmtReq = '0;
	endtask
	task automatic rdChk(input logic [4:0] a, input logic [15:0] e);
		@(negedge clk);
		mgmtReq = {1'h0, 1'h1, a, 16'h0000};
		@(negedge clk);
		mgmtReq = '0;
		chk(mgmtRdValid, 16'h0001);
		chk(mgmtRdData, e);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic regTest;
		rdChk(CTRL_ONE_ADDR, 16'h0000);
		rdChk(CTRL_TWO_ADDR, 16'h0000);
		wr(CTRL_ONE_ADDR, 16'hFFFF);
		wr(CTRL_TWO_ADDR, 16'hFFFF);
		wr(5'h0B, 16'hFFFF);
		rdChk(CTRL_ONE_ADDR, 16'h0122);
		rdChk(CTRL_TWO_ADDR, 16'h0026);
		rdChk(5'h0B, 16'h0000);
	endtask
	task automatic ceTest;
		ce = 1'h0;
		wr(CTRL_ONE_ADDR, 16'h0000);
		ce = 1'h1;
		rdChk(CTRL_ONE_ADDR, 16'h0122);
	endtask
	task automatic resetTest;
		sysRst = 1'h1;
		repeat (2) @(negedge clk);
		sysRst = 1'h0;
		rdChk(CTRL_ONE_ADDR, 16'h0000);
		rdChk(CTRL_TWO_ADDR, 16'h0000);
	endtask
	task automatic diagTest(input logic en);
		int n;
		n = 0;
		wr(CTRL_ONE_ADDR, {7'h00, en, 8'h00});
		mac.setLine(1'h1, 1'h0);
		mac.setLine(1'h0, 1'h0);
		repeat (4) begin
			@(negedge clk);
			n += diagStart;
		end
		chk(n[15:0], {15'h0000, en});
	endtask
	task automatic xoverTest;
		int t;
		logic s;
		t = 0;
		chk(autoMdixOn, 16'h0000);
		chk(mdixSwap, 16'h0000);
		wr(CTRL_ONE_ADDR, 16'h0020);
		s = mdixSwap;
		repeat (40) begin
			@(negedge clk);
			t += (mdixSwap !== s);
			s = mdixSwap;
		end
		chk(autoMdixOn, 16'h0001);
		chk({15'h0000, t > 1}, 16'h0001);
		mac.setLine(1'h0, 1'h1);
		repeat (2) @(negedge clk);
		s = mdixSwap;
		repeat (30) @(negedge clk);
		chk(mdixSwap, s);
		mac.setLine(1'h1, 1'h0);
		wr(CTRL_ONE_ADDR, 16'h0000);
		@(negedge clk);
		chk(mdixSwap, 16'h0000);
	endtask
	task automatic duplexTest;
		logic [5:0] tab [6] = '{6'h35, 6'h2D, 6'h24, 6'h30, 6'h14, 6'h17};
		foreach (tab[i]) begin
			wr(CTRL_TWO_ADDR, {10'h000, tab[i][5], 5'h00});
			anEnable = tab[i][4];
			forced100 = tab[i][3];
			partnerForced100 = tab[i][2];
			ieeeFullDuplex = tab[i][1];
			repeat (2) @(negedge clk);
			chk(fullDuplex, {15'h0000, tab[i][0]});
		end
	endtask
	task automatic rxTest(input logic early);
		wr(CTRL_ONE_ADDR, {14'h0000, early, 1'h0});
		mac.sym(4'h8);
		mac.sym(4'h4);
		chk(rxDv, {15'h0000, early});
		mac.sym(4'h0);
		chk(rxDv, 16'h0001);
		mac.sym(4'h2);
		mac.quiet();
		chk(rxDv, 16'h0000);
		mac.sym(4'h8);
		mac.sym(4'h0);
		mac.quiet();
		chk(rxEr, {15'h0000, early});
		@(negedge clk);
		chk(rxDv, 16'h0000);
	endtask
	task automatic idleTest(input logic en);
		wr(CTRL_TWO_ADDR, {13'h0000, en, 2'h0});
		mac.sym(4'h3);
		mac.quiet();
		chk(rxEr, {15'h0000, en});
	endtask
	task automatic txTest(input logic dis, input int n, input logic e);
		wr(CTRL_TWO_ADDR, {14'h0000, dis, 1'h0});
		mac.tx(n, e);
		chk(txErOut, {15'h0000, e});
		@(negedge clk);
		chk(txEnOut, {15'h0000, ~dis & n[0]});
		chk(txErOut, {15'h0000, ~dis & n[0]});
		@(negedge clk);
		chk(txEnOut, 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		nFail++;
		results();
	end
	initial begin
		sysRst = 1'h1;
		ce = 1'h1;
		mgmtReq = '0;
		{anEnable, forced100, partnerForced100, ieeeFullDuplex} = 4'h0;
		nFail = 0;
		checked = 0;
		repeat (2) @(negedge clk);
		sysRst = 1'h0;
		regTest();
		ceTest();
		resetTest();
		diagTest(1'h1);
		diagTest(1'h0);
		xoverTest();
		duplexTest();
		rxTest(1'h1);
		rxTest(1'h0);
		idleTest(1'h1);
		idleTest(1'h0);
		txTest(1'h0, 3, 1'h0);
		txTest(1'h0, 4, 1'h1);
		txTest(1'h1, 3, 1'h1);
		results();
	end
endmodule
